// file: inc/tsp_pkg.sv
// Shared constants and types for the touch converter serial port.
package tsp_pkg;
   localparam int unsigned CTRL_BITS       = 8;
   localparam int unsigned RESULT_BITS     = 12;
   localparam int unsigned START_BIT_POS   = 7;
   localparam int unsigned REF_MODE_POS    = 2;
   localparam int unsigned PD_POS_LO       = 0;
   localparam logic [3:0]  ACQ_FIRST_FALL  = 4'h5;
   localparam logic [3:0]  ACQ_LAST_FALL   = 4'h8;
   localparam int unsigned SYNC_STAGES     = 2;
   localparam logic [11:0] RESULT_RESET    = 12'h000;

   typedef enum logic [1:0] {
      TSP_IDLE,
      TSP_CMD,
      TSP_BUSY,
      TSP_SHIFT
   } tsp_state_t;
endpackage : tsp_pkg

// file: src/tsp_serial_port.sv
// Serial host port of the touch converter: command capture, busy pulse and result shift.
// Notes on behaviour
// [R1] Serial input is sampled on each rising serial clock edge.
// [R2] Input bits are taken only while chip select is low.
// [R3] Serial output changes only on falling serial clock edges.
// [R4] Output and busy are released (enable low) while chip select is high.
// [R5] Busy is high for one serial clock period before the first result bit.
// [R6] The serial clock alone paces shifting and conversion.
// [R7] Conversion lasts a fixed count of serial clock periods.
// [R8] The host keeps the serial clock duty between forty and sixty percent.
// [R9] Acquisition runs from the fifth to the eighth falling serial clock edge.
// [R10] Reference mode bit one selects single-ended, zero differential.
// [R11] Pen interrupt is pulled low while touched and enabled; this port has no enable and pulls it low whenever touched.
// [R12] The result leaves most significant bit first, one bit per clock.
`timescale 1ns/1ns
module tsp_serial_port #(
   parameter int unsigned RESULT_W = tsp_pkg::RESULT_BITS
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                serial_clock,
   input  wire logic                cs_n,
   input  wire logic                din,
   output logic                     dout_o,
   output logic                     dout_oe,
   output logic                     busy_o,
   output logic                     busy_oe,
   output logic                     pen_touch_irq_n_o,
   output logic                     pen_touch_irq_n_oe,
   input  wire logic                pen_touched,
   input  wire logic [RESULT_W-1:0] sample_data,
   input  wire logic                sample_valid,
   output logic                     sample_ready,
   output logic                     acquire_o,
   output logic                     ref_mode_select,
   output logic                     cmd_valid_o,
   output logic [tsp_pkg::CTRL_BITS-1:0] cmd_word_o
);
   logic [2:0] sclk_q;
   logic [1:0] csn_q;
   logic [1:0] din_q;
   logic [1:0] pen_q;
   logic       rise;
   logic       fall;
   logic       sel;
   tsp_pkg::tsp_state_t   state_q;
   logic [3:0]            fall_cnt_q;
   logic [3:0]            bit_cnt_q;
   logic [tsp_pkg::CTRL_BITS-1:0] shreg_q;
   logic [RESULT_W-1:0]   out_q;
   // Two-entry buffer holding conversion results until the shifter needs them.
   logic [RESULT_W-1:0]   buf_q [2];
   logic [1:0]            cnt_q;
   logic                  wr_ptr_q;
   logic                  rd_ptr_q;
   logic                  pop;

   // Serial clock and pins are synchronised; pins are decoded at the second stage, the serial clock from its second and third.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclk_q <= 3'h0;
         csn_q  <= 2'h3;
         din_q  <= 2'h0;
         pen_q  <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], serial_clock};
         csn_q  <= {csn_q[0], cs_n};
         din_q  <= {din_q[0], din};
         pen_q  <= {pen_q[0], pen_touched};
      end
   end
   assign rise = sclk_q[1] & ~sclk_q[2]; // [R1] [R6]
   assign fall = ~sclk_q[1] & sclk_q[2]; // [R3] [R6]
   assign sel  = ~csn_q[1];               // [R2]

   assign sample_ready = (cnt_q != 2'h2);
   assign pop = fall && state_q == tsp_pkg::TSP_BUSY && cnt_q != 2'h0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q    <= 2'h0;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         buf_q[0] <= tsp_pkg::RESULT_RESET;
         buf_q[1] <= tsp_pkg::RESULT_RESET;
      end else begin
         if (sample_valid && sample_ready) begin
            buf_q[wr_ptr_q] <= sample_data;
            wr_ptr_q        <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         cnt_q <= cnt_q + 2'((sample_valid && sample_ready) ? 1 : 0) - 2'(pop ? 1 : 0);
      end
   end

   // Control word capture on rising edges; a set start bit begins a frame.
   always_ff @(posedge clk) begin
      if (sys_rst || !sel) begin
         shreg_q     <= '0;
         cmd_valid_o <= 1'b0;
      end else begin
         cmd_valid_o <= 1'b0;
         if (rise && state_q == tsp_pkg::TSP_IDLE && din_q[1]) begin // [R1] [R2]
            shreg_q <= {{(tsp_pkg::CTRL_BITS-1){1'b0}}, 1'b1};
         end else if (rise && state_q == tsp_pkg::TSP_CMD) begin
            shreg_q <= {shreg_q[tsp_pkg::CTRL_BITS-2:0], din_q[1]}; // [R1]
            if (shreg_q[tsp_pkg::CTRL_BITS-2]) begin
               cmd_valid_o <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_word_o      <= '0;
         ref_mode_select <= 1'b0;
      end else if (cmd_valid_o) begin
         cmd_word_o      <= shreg_q;
         ref_mode_select <= shreg_q[tsp_pkg::REF_MODE_POS]; // [R10]
      end
   end

   // Frame sequencer: falls are counted from the start bit until the busy period ends.
   always_ff @(posedge clk) begin
      if (sys_rst || !sel) begin
         state_q    <= tsp_pkg::TSP_IDLE;
         fall_cnt_q <= 4'h0;
         bit_cnt_q  <= 4'h0;
      end else begin
         case (state_q)
            tsp_pkg::TSP_IDLE: begin
               fall_cnt_q <= 4'h0;
               if (rise && din_q[1]) begin
                  state_q <= tsp_pkg::TSP_CMD;
               end
            end
            tsp_pkg::TSP_CMD: begin
               if (fall) begin
                  fall_cnt_q <= fall_cnt_q + 4'h1;
                  // Busy waits for the eighth fall so the eighth rise still lands a command bit.
                  if (fall_cnt_q + 4'h1 == tsp_pkg::ACQ_LAST_FALL) begin
                     state_q <= tsp_pkg::TSP_BUSY;
                  end
               end
            end
            tsp_pkg::TSP_BUSY: begin
               if (fall) begin // [R5] [R7]
                  fall_cnt_q <= fall_cnt_q + 4'h1;
                  state_q    <= tsp_pkg::TSP_SHIFT;
                  bit_cnt_q  <= 4'(RESULT_W - 1);
               end
            end
            tsp_pkg::TSP_SHIFT: begin
               if (fall) begin // [R12] [R7]
                  if (bit_cnt_q == 4'h0) begin
                     state_q <= tsp_pkg::TSP_IDLE;
                  end else begin
                     bit_cnt_q <= bit_cnt_q - 4'h1;
                  end
               end
            end
            default: state_q <= tsp_pkg::TSP_IDLE;
         endcase
      end
   end

   // Result is latched when busy ends, then shifted MSB first on falls.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_q <= tsp_pkg::RESULT_RESET;
      end else if (pop) begin
         out_q <= buf_q[rd_ptr_q];
      end else if (fall && state_q == tsp_pkg::TSP_BUSY) begin
         // An empty buffer must not replay bits left by a frame cut short.
         out_q <= tsp_pkg::RESULT_RESET;
      end else if (fall && state_q == tsp_pkg::TSP_SHIFT) begin
         out_q <= {out_q[RESULT_W-2:0], 1'b0}; // [R12]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dout_o  <= 1'b0;
         dout_oe <= 1'b0;
         busy_o  <= 1'b0;
         busy_oe <= 1'b0;
      end else begin
         dout_oe <= sel; // [R4]
         busy_oe <= sel; // [R4]
         if (!sel) begin
            dout_o <= 1'b0;
            busy_o <= 1'b0;
         end else if (fall) begin // [R3]
            busy_o <= (state_q == tsp_pkg::TSP_CMD) &&
                      (fall_cnt_q + 4'h1 == tsp_pkg::ACQ_LAST_FALL); // [R5]
            if (pop) begin
               dout_o <= buf_q[rd_ptr_q][RESULT_W-1]; // [R12]
            end else if (state_q == tsp_pkg::TSP_SHIFT && bit_cnt_q != 4'h0) begin
               dout_o <= out_q[RESULT_W-2]; // [R12]
            end else begin
               dout_o <= 1'b0;
            end
         end
      end
   end

   // Acquisition window spans the fifth to the eighth falling edge.
   always_ff @(posedge clk) begin
      if (sys_rst || !sel) begin
         acquire_o <= 1'b0;
      end else if (fall) begin
         if (fall_cnt_q + 4'h1 == tsp_pkg::ACQ_FIRST_FALL) begin
            acquire_o <= 1'b1; // [R9]
         end else if (fall_cnt_q + 4'h1 == tsp_pkg::ACQ_LAST_FALL) begin
            acquire_o <= 1'b0; // [R9]
         end
      end
   end

   // Open-drain pen output: drive low while touched, release otherwise.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pen_touch_irq_n_o  <= 1'b0;
         pen_touch_irq_n_oe <= 1'b0;
      end else begin
         pen_touch_irq_n_o  <= 1'b0;
         pen_touch_irq_n_oe <= pen_q[1]; // [R11]
      end
   end

   busy_release_a: assert property (@(posedge clk) disable iff (sys_rst)
      csn_q[1] |=> !busy_oe && !dout_oe) else $error("outputs driven while deselected"); // [R4]
   sequence busy_hold_s;
      busy_o && sel && !fall;
   endsequence
   sequence busy_end_s;
      busy_o && sel && fall;
   endsequence
   busy_one_a: assert property (@(posedge clk) disable iff (sys_rst)
      busy_hold_s |=> busy_o) else $error("busy dropped early"); // [R5]
   busy_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
      busy_end_s |=> !busy_o) else $error("busy held past one period"); // [R5]
   dout_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
      (sel && $past(sel) && $changed(dout_o)) |-> $past(fall)) else $error("dout moved off fall"); // [R3]
   pen_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
      pen_q[1] |=> pen_touch_irq_n_oe && !pen_touch_irq_n_o) else $error("pen not pulled"); // [R11]
   acq_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(acquire_o) |-> $past(fall_cnt_q) == tsp_pkg::ACQ_FIRST_FALL - 4'h1)
      else $error("acquire late"); // [R9]
   ref_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_valid_o |=> ref_mode_select == $past(shreg_q[2])) else $error("ref mode wrong"); // [R10]
   shift_ord_a: assert property (@(posedge clk) disable iff (sys_rst)
      pop |=> out_q == $past(buf_q[rd_ptr_q])) else $error("result not loaded"); // [R12]
   busy_pos_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(busy_o) |-> state_q == tsp_pkg::TSP_BUSY) else $error("busy off place"); // [R5]
endmodule : tsp_serial_port

// file: verification/tsp_host_model.sv
// Host model that clocks command frames in and captures the reply.
`timescale 1ns/1ns
module tsp_host_model (
   input  wire logic clk,
   input  wire logic dout,
   input  wire logic busy,
   output logic      serial_clock,
   output logic      cs_n,
   output logic      din
);
   initial begin
      serial_clock = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end
   // A released data line toggles so a stale level never looks like data.
   always @(negedge clk) if (cs_n) din <= ~din;
   // Four system cycles per half keeps the duty at fifty percent.
   task automatic frame(input logic [7:0] cmd, input int n,
                        output logic [11:0] res, output logic [2:0] b);
      res = 12'h000;
      b = 3'h0;
      @(negedge clk);
      cs_n = 1'b0;
      @(negedge clk);
      din = cmd[7];
      for (int i = 0; i < n; i++) begin
         repeat (4) @(negedge clk);
         if (i >= 9) res = {res[10:0], dout};
         if (i >= 7 && i <= 9) b = {b[1:0], busy};
         serial_clock = 1'b1;
         repeat (4) @(negedge clk);
         serial_clock = 1'b0;
         din = (i < 7) ? cmd[6 - i] : 1'b0;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
   endtask : frame
endmodule : tsp_host_model

// file: verification/tsp_serial_port_tb.sv
// Self-checking bench for the touch converter serial port.
`timescale 1ns/1ns
module tsp_serial_port_tb;
   logic        clk, sys_rst, serial_clock, cs_n, din, pen_touched, sample_valid;
   logic        sample_ready, dout_o, dout_oe, busy_o, busy_oe, pen_o, pen_oe;
   logic        acquire_o, ref_mode_select, cmd_valid_o;
   logic [11:0] sample_data, res, q[$];
   logic [7:0]  cmd_word_o;
   logic [2:0]  b;
   int          err_total, samples_checked, cmd_n, seed;
   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(posedge clk) if (cmd_valid_o === 1'b1) cmd_n++;
   tsp_serial_port u_dut (.clk(clk), .sys_rst(sys_rst), .serial_clock(serial_clock),
      .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .busy_o(busy_o),
      .busy_oe(busy_oe), .pen_touch_irq_n_o(pen_o), .pen_touch_irq_n_oe(pen_oe),
      .pen_touched(pen_touched), .sample_data(sample_data), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .acquire_o(acquire_o), .ref_mode_select(ref_mode_select),
      .cmd_valid_o(cmd_valid_o), .cmd_word_o(cmd_word_o));
   tsp_host_model u_host (.clk(clk), .dout(dout_oe ? dout_o : 1'bz), .busy(busy_o),
      .serial_clock(serial_clock), .cs_n(cs_n), .din(din));
   task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   function automatic logic exp_ref(input logic [7:0] c);
      return c[tsp_pkg::REF_MODE_POS];
   endfunction : exp_ref
   task automatic push(input logic [11:0] v);
      @(negedge clk);
      sample_data = v;
      sample_valid = 1'b1;
      if (sample_ready === 1'b1) q.push_back(v);
      @(negedge clk);
      sample_valid = 1'b0;
   endtask : push
   task automatic run(input logic [7:0] c);
      int n0;
      logic [11:0] e;
      n0 = cmd_n;
      e = (q.size() > 0) ? q.pop_front() : 12'h000;
      fork
         u_host.frame(c, 21, res, b);
         begin
            repeat (3) @(posedge serial_clock);
            chk("acquire", 12'(acquire_o), 12'h0);
            chk("oe_on", 12'(dout_oe & busy_oe), 12'h1);
            repeat (4) @(posedge serial_clock);
            chk("acquire", 12'(acquire_o), 12'h1);
         end
      join
      chk("result", res, e);
      chk("busy", 12'(b), 12'h2);
      chk("cmd_word", 12'(cmd_word_o), 12'(c));
      chk("ref_mode", 12'(ref_mode_select), 12'(exp_ref(c)));
      chk("cmd_count", 12'(cmd_n - n0), 12'h1);
      repeat (4) @(negedge clk);
      chk("oe_off", 12'(dout_oe | busy_oe), 12'h0);
      $display("frame %h done", c);
   endtask : run
   initial begin
      seed = 32'h92834bab;
      sys_rst = 1'b1;
      pen_touched = 1'b0;
      sample_valid = 1'b0;
      sample_data = 12'h000;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      chk("oe_idle", 12'(dout_oe | busy_oe), 12'h0);
      run(8'h84);
      push(12'hfff);
      push(12'h800);
      push(12'h001);
      chk("ready", 12'(sample_ready), 12'h0);
      run(8'h80);
      run(8'hfb);
      // An aborted command must leave no trace in the next frame.
      u_host.frame(8'hff, 4, res, b);
      for (int i = 0; i < 6; i++) begin
         push(12'($random(seed)));
         run({1'b1, 7'($random(seed))});
      end
      pen_touched = 1'b1;
      repeat (5) @(negedge clk);
      chk("pen", {10'h000, pen_oe, pen_o}, 12'h2);
      pen_touched = 1'b0;
      repeat (5) @(negedge clk);
      chk("pen", 12'(pen_oe), 12'h0);
      $display("pen test done");
      finish_test();
   end
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      finish_test();
   end
endmodule : tsp_serial_port_tb
